// file: fwl_map.vh
/*
 * Constants of the firmware RAM loader: register offsets, field
 * positions, reset values, sizes and timing figures.
 * Assumes inclusion by bare name from the loader design files.
 */
`ifndef FWL_MAP_VH
`define FWL_MAP_VH

// Register offsets within the I/O window
`define FWL_OFF_DATA_ADDR 3'h0
`define FWL_OFF_CTRL 3'h4

// Control register field positions
`define FWL_BIT_LOAD_ERR 0
`define FWL_BIT_LOAD_DONE 2
`define FWL_BIT_ADDR_FOLLOWS 3

// Reset values
`define FWL_DATA_ADDR_RST 32'hFFFFFFFF
`define FWL_CTRL_RST 32'h00000000

// Program RAM: 16-bit words, depth 2**FWL_RAM_AW
`define FWL_RAM_DW 16
`define FWL_RAM_AW 12

// Write buffer
`define FWL_FIFO_DEPTH 16
`define FWL_FIFO_AW 4

// Timing
`define FWL_CLK_PERIOD_NS 5
`define FWL_RETRY_TIMEOUT_NS 40960
`define FWL_STALL_CW 16

`endif

// file: fwl_fifo.v
/*
 * Synchronous FIFO with valid/ready on both sides and a flush.
 * Assumes a single clock and an asynchronous active-high reset.
 */
`timescale 1ns/1ps
`default_nettype none

module fwl_fifo #(
    parameter W = 28,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire mclk_i,
    input wire rst_i,
    input wire flush_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);

    reg [W-1:0] mem [0:DEPTH-1];
    reg [AW-1:0] rd_ptr;
    reg [AW-1:0] wr_ptr;
    reg [AW:0] count;
    wire push;
    wire pop;

    assign in_ready_o = (count != DEPTH[AW:0]);
    assign out_valid_o = (count != {(AW+1){1'b0}});
    assign out_data_o = mem[rd_ptr];
    assign push = in_valid_i && in_ready_o;
    assign pop = out_valid_o && out_ready_i;

    always @(posedge mclk_i) begin
        if (push) begin
            mem[wr_ptr] <= in_data_i;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ptr <= {AW{1'b0}};
            wr_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else if (flush_i) begin
            rd_ptr <= {AW{1'b0}};
            wr_ptr <= {AW{1'b0}};
            count <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (pop) begin
                rd_ptr <= rd_ptr + {{(AW-1){1'b0}}, 1'b1};
            end
            if (push && !pop) begin
                count <= count + {{AW{1'b0}}, 1'b1};
            end else if (pop && !push) begin
                count <= count - {{AW{1'b0}}, 1'b1};
            end
        end
    end

endmodule

`default_nettype wire

// file: fwl_loader.v
/*
 * Firmware RAM loader: two-register I/O window, write buffer,
 * 16-bit program RAM with clear-on-reset and an embedded core
 * reset hold. Assumes I/O requests synchronous to mclk_i, one
 * request per cycle, each answered by ack or retry on the next edge.
 */
`timescale 1ns/1ps
`default_nettype none
`include "fwl_map.vh"

module fwl_loader #(
    parameter [`FWL_STALL_CW-1:0] RETRY_CYCLES =
        `FWL_RETRY_TIMEOUT_NS / `FWL_CLK_PERIOD_NS
) (
    input wire mclk_i,
    input wire rst_i,
    input wire global_reset_in_i,
    input wire io_req_i,
    input wire io_wr_i,
    input wire [2:0] io_addr_i,
    input wire [31:0] io_wdata_i,
    output reg [31:0] io_rdata_o,
    output reg io_ack_o,
    output reg io_retry_o,
    input wire [`FWL_RAM_AW-1:0] core_raddr_i,
    output reg [`FWL_RAM_DW-1:0] core_rdata_o,
    output reg core_reset_o
);

    localparam AW = `FWL_RAM_AW;
    localparam DW = `FWL_RAM_DW;
    localparam FW = AW + DW;
    localparam CW = `FWL_STALL_CW;

    localparam [2:0] ST_CLEAR = 3'h1;
    localparam [2:0] ST_LOAD = 3'h2;
    localparam [2:0] ST_READY = 3'h4;

    reg [2:0] state;
    reg [2:0] next_state;
    reg [AW-1:0] clr_addr;
    reg addr_follows;
    reg load_done;
    reg load_err;
    reg [31:0] data_addr;
    reg [AW-1:0] wptr;
    reg wptr_ovf;
    reg [CW-1:0] stall_cnt;
    reg [DW-1:0] prog_ram [0:(1<<AW)-1];

    wire sel_data;
    wire sel_ctrl;
    wire wr_data;
    wire rd_data;
    wire wr_ctrl;
    wire rd_ctrl;
    wire addr_phase;
    wire data_phase;
    wire addr_bad;
    wire push_try;
    wire push;
    wire drop_to;
    wire refuse;
    wire drop_ovf;
    wire err_set;
    wire timed_out;
    wire fifo_in_ready;
    wire fifo_out_valid;
    wire fifo_out_ready;
    wire [FW-1:0] fifo_out_data;
    wire ram_we;
    wire [AW-1:0] ram_waddr;
    wire [DW-1:0] ram_wdata;
    wire [31:0] ctrl_rd_value;

    // Address decode of the two-register window
    assign sel_data = (io_addr_i == `FWL_OFF_DATA_ADDR);
    assign sel_ctrl = (io_addr_i == `FWL_OFF_CTRL);
    assign wr_data = io_req_i && io_wr_i && sel_data;
    assign rd_data = io_req_i && !io_wr_i && sel_data;
    assign wr_ctrl = io_req_i && io_wr_i && sel_ctrl;
    assign rd_ctrl = io_req_i && !io_wr_i && sel_ctrl;

    // A port write is an address or a data word, never both
    assign addr_phase = wr_data && addr_follows;
    assign data_phase = wr_data && !addr_follows;
    assign addr_bad = |io_wdata_i[31:AW];

    // Writes past the top of the RAM are lost, not wrapped
    assign drop_ovf = data_phase && wptr_ovf;
    assign push_try = data_phase && !wptr_ovf;
    assign timed_out = (stall_cnt >= RETRY_CYCLES);
    assign push = push_try && fifo_in_ready;
    assign refuse = push_try && !fifo_in_ready && !timed_out;
    assign drop_to = push_try && !fifo_in_ready && timed_out;
    assign err_set = drop_to || drop_ovf || (addr_phase && addr_bad);

    // Value returned before the read clears the error flag
    assign ctrl_rd_value = {28'h0000000, 1'b0, load_done, 1'b0,
                            load_err};

    // Buffer drains only after the RAM clear walk is over
    assign fifo_out_ready = (state != ST_CLEAR);

    fwl_fifo #(
        .W(FW),
        .DEPTH(`FWL_FIFO_DEPTH),
        .AW(`FWL_FIFO_AW)
    ) u_wbuf (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .flush_i(global_reset_in_i),
        .in_valid_i(push_try),
        .in_ready_o(fifo_in_ready),
        .in_data_i({wptr, io_wdata_i[DW-1:0]}),
        .out_valid_o(fifo_out_valid),
        .out_ready_i(fifo_out_ready),
        .out_data_o(fifo_out_data)
    );

    // RAM write port: clear walk first, then buffered data
    assign ram_we = (state == ST_CLEAR) || fifo_out_valid;
    assign ram_waddr = (state == ST_CLEAR) ? clr_addr :
                       fifo_out_data[FW-1:DW];
    assign ram_wdata = (state == ST_CLEAR) ? {DW{1'b0}} :
                       fifo_out_data[DW-1:0];

    // Array has no reset; it is cleared by the walk instead
    always @(posedge mclk_i) begin
        if (ram_we) begin
            prog_ram[ram_waddr] <= ram_wdata;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            core_rdata_o <= {DW{1'b0}};
        end else begin
            core_rdata_o <= prog_ram[core_raddr_i];
        end
    end

    // Loader sequencing
    always @* begin
        next_state = state;
        case (state)
            ST_CLEAR: begin
                if (clr_addr == {AW{1'b1}}) begin
                    next_state = ST_LOAD;
                end
            end
            ST_LOAD: begin
                if (load_done && !fifo_out_valid && !push &&
                    !(wr_ctrl && !io_wdata_i[`FWL_BIT_LOAD_DONE])) begin
                    next_state = ST_READY;
                end
            end
            ST_READY: begin
                if (push || (wr_ctrl &&
                    !io_wdata_i[`FWL_BIT_LOAD_DONE])) begin
                    next_state = ST_LOAD;
                end
            end
            default: begin
                next_state = ST_CLEAR;
            end
        endcase
        if (global_reset_in_i) begin
            next_state = ST_CLEAR;
        end
    end

    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            state <= ST_CLEAR;
            clr_addr <= {AW{1'b0}};
            core_reset_o <= 1'b1;
        end else begin
            state <= next_state;
            core_reset_o <= (next_state != ST_READY);
            if (global_reset_in_i) begin
                clr_addr <= {AW{1'b0}};
            end else if (state == ST_CLEAR) begin
                clr_addr <= clr_addr + {{(AW-1){1'b0}}, 1'b1};
            end
        end
    end

    // Time spent with the buffer full; a stuck RAM ends in a drop
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            stall_cnt <= {CW{1'b0}};
        end else if (global_reset_in_i || fifo_in_ready || drop_to) begin
            stall_cnt <= {CW{1'b0}};
        end else if (!timed_out) begin
            stall_cnt <= stall_cnt + {{(CW-1){1'b0}}, 1'b1};
        end
    end

    // Control register and write pointer
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            addr_follows <= 1'b0;
            load_done <= 1'b0;
            load_err <= 1'b0;
            data_addr <= `FWL_DATA_ADDR_RST;
            wptr <= {AW{1'b0}};
            wptr_ovf <= 1'b0;
        end else if (global_reset_in_i) begin
            addr_follows <= 1'b0;
            load_done <= 1'b0;
            load_err <= 1'b0;
            data_addr <= `FWL_DATA_ADDR_RST;
            wptr <= {AW{1'b0}};
            wptr_ovf <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                addr_follows <= io_wdata_i[`FWL_BIT_ADDR_FOLLOWS];
                load_done <= io_wdata_i[`FWL_BIT_LOAD_DONE];
            end else if (addr_phase) begin
                addr_follows <= 1'b0;
            end
            // A new error in the cycle of a read still sticks
            if (err_set) begin
                load_err <= 1'b1;
            end else if (rd_ctrl) begin
                load_err <= 1'b0;
            end
            if (wr_data && !refuse) begin
                data_addr <= io_wdata_i;
            end
            if (addr_phase) begin
                wptr <= io_wdata_i[AW-1:0];
                wptr_ovf <= addr_bad;
            end else if (push || drop_to) begin
                wptr <= wptr + {{(AW-1){1'b0}}, 1'b1};
                if (wptr == {AW{1'b1}}) begin
                    wptr_ovf <= 1'b1;
                end
            end
        end
    end

    // Answer every request on the next edge
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            io_rdata_o <= 32'h00000000;
            io_ack_o <= 1'b0;
            io_retry_o <= 1'b0;
        end else begin
            io_ack_o <= io_req_i && !refuse;
            io_retry_o <= refuse;
            if (rd_ctrl) begin
                io_rdata_o <= ctrl_rd_value;
            end else if (rd_data) begin
                io_rdata_o <= data_addr;
            end else begin
                io_rdata_o <= 32'h00000000;
            end
        end
    end

endmodule

`default_nettype wire

// file: fwl_monitor.sv
/* Port checker for fwl_loader, bound onto every instance.
   Assumes the loader's port names and the fwl_map.vh constants. */
`timescale 1ns/1ps
`default_nettype none
`include "fwl_map.vh"
module fwl_loader_chk #(
    parameter [`FWL_STALL_CW-1:0] RETRY_CYCLES = 16'h2000
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic global_reset_in_i,
    input wire logic io_req_i,
    input wire logic io_wr_i,
    input wire logic [2:0] io_addr_i,
    input wire logic [31:0] io_wdata_i,
    input wire logic [31:0] io_rdata_o,
    input wire logic io_ack_o,
    input wire logic io_retry_o,
    input wire logic [`FWL_RAM_AW-1:0] core_raddr_i,
    input wire logic [`FWL_RAM_DW-1:0] core_rdata_o,
    input wire logic core_reset_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    wire ctrl_wr = io_req_i && io_wr_i && io_addr_i == `FWL_OFF_CTRL;
    logic done_seen;
    logic data_wr_q;
    logic [`FWL_STALL_CW:0] refuse_age;
    // Last written done; the core may only run once it was set
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            done_seen <= 1'b0;
        end else if (global_reset_in_i) begin
            done_seen <= 1'b0;
        end else if (ctrl_wr) begin
            done_seen <= io_wdata_i[`FWL_BIT_LOAD_DONE];
        end
    end
    // Age since the first refusal; an acked data write or a global reset ends it,
    // so the age can exceed the time the buffer really stayed full
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            data_wr_q <= 1'b0;
            refuse_age <= '0;
        end else begin
            data_wr_q <= io_req_i && io_wr_i &&
                         io_addr_i == `FWL_OFF_DATA_ADDR;
            if (global_reset_in_i || (io_ack_o && data_wr_q)) begin
                refuse_age <= '0;
            end else if ((io_retry_o || refuse_age != '0) &&
                         !(&refuse_age)) begin
                refuse_age <= refuse_age + 1'b1;
            end
        end
    end
    sequence ctrl_rd;
        io_req_i && !io_wr_i && io_addr_i == `FWL_OFF_CTRL;
    endsequence
    sequence quiet_reread;
        ctrl_rd ##1 !io_req_i ##1 ctrl_rd;
    endsequence
    chk_one_answer: assert property (
        io_req_i |=> io_ack_o != io_retry_o) else $error("Bad answer");
    chk_no_answer: assert property (
        !io_req_i |=> !io_ack_o && !io_retry_o) else $error("Stray answer");
    chk_retry_data: assert property (
        io_req_i && !(io_wr_i && io_addr_i == `FWL_OFF_DATA_ADDR)
        |=> !io_retry_o) else $error("Retry on non-data access");
    chk_rsvd_zero: assert property (
        ctrl_rd |=> io_rdata_o[31:3] == 29'h0 && !io_rdata_o[1])
        else $error("Reserved control bits not zero");
    chk_err_cleared: assert property (
        quiet_reread |=> !io_rdata_o[0]) else $error("Error not cleared");
    chk_done_hold: assert property (
        ctrl_wr && !io_wdata_i[`FWL_BIT_LOAD_DONE] |=> ##[0:2] core_reset_o)
        else $error("Core not held after done cleared");
    chk_global_reset_in_hold: assert property (
        global_reset_in_i |=> ##[0:1] core_reset_o)
        else $error("Core not held on global reset");
    chk_release_done: assert property (
        $fell(core_reset_o) |-> done_seen || $past(done_seen))
        else $error("Core released without done");
    chk_rdata_idle: assert property (
        !io_ack_o |-> io_rdata_o == 32'h0) else $error("Read data not idle");
    chk_retry_limit: assert property (
        io_retry_o |-> refuse_age <= RETRY_CYCLES)
        else $error("Retry outlasts time-out");
endmodule
bind fwl_loader fwl_loader_chk #(.RETRY_CYCLES(RETRY_CYCLES))
    fwl_loader_chk_i (
    .mclk_i(mclk_i),
    .rst_i(rst_i),
    .global_reset_in_i(global_reset_in_i),
    .io_req_i(io_req_i),
    .io_wr_i(io_wr_i),
    .io_addr_i(io_addr_i),
    .io_wdata_i(io_wdata_i),
    .io_rdata_o(io_rdata_o),
    .io_ack_o(io_ack_o),
    .io_retry_o(io_retry_o),
    .core_raddr_i(core_raddr_i),
    .core_rdata_o(core_rdata_o),
    .core_reset_o(core_reset_o)
);
`default_nettype wire

// file: fwl_host.sv
/* Host driver model for the loader I/O window.
   Assumes each taken request is answered on the next edge. */
`timescale 1ns/1ps
`default_nettype none
module fwl_host (
    input wire logic mclk_i,
    output logic io_req_o,
    output logic io_wr_o,
    output logic [2:0] io_addr_o,
    output logic [31:0] io_wdata_o,
    input wire logic [31:0] io_rdata_i,
    input wire logic io_ack_i,
    input wire logic io_retry_i
);
    initial begin
        io_req_o = 1'b0;
        io_wr_o = 1'b0;
        io_addr_o = 3'h0;
        io_wdata_o = 32'h0;
    end
    task xfer(input logic w, input logic [2:0] a, input logic [31:0] d,
              output logic [31:0] q, output logic rt);
        @(posedge mclk_i);
        io_req_o <= 1'b1;
        io_wr_o <= w;
        io_addr_o <= a;
        io_wdata_o <= d;
        @(posedge mclk_i);
        io_req_o <= 1'b0;
        // Released lines carry junk so stale values are never trusted
        io_wr_o <= ~w;
        io_addr_o <= ~a;
        io_wdata_o <= ~d;
        #1;
        q = io_rdata_i;
        rt = io_retry_i | ~io_ack_i;
    endtask
    // A refused write must be repeated by the host
    task put(input logic [2:0] a, input logic [31:0] d);
        logic [31:0] q;
        logic rt;
        int n;
        n = 0;
        rt = 1'b1;
        while (rt && n < 200) begin
            xfer(1'b1, a, d, q, rt);
            n++;
        end
    endtask
    task close_load(output logic [31:0] st);
        logic rt;
        xfer(1'b1, 3'h4, 32'h4, st, rt);
        xfer(1'b0, 3'h4, 32'h0, st, rt);
    endtask
endmodule
`default_nettype wire

// file: tb_top.sv
/* Self-checking bench: host model drives fwl_loader, a RAM model
   checks the core port. Assumes the loader, FIFO and host files. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk = 1'b0;
    logic rst, global_reset_in;
    logic [11:0] craddr;
    wire req, wr, ack, retry, creset;
    wire [2:0] addr;
    wire [31:0] wdata, rdata;
    wire [15:0] crdata;
    logic [31:0] q, d;
    logic rt;
    integer seed, fail_count, total_checks, i;
    integer cyc = 0;
    int mem[int];
    always #2.5 mclk = ~mclk;
    // Short time-out keeps the refusal scenario brief
    fwl_loader #(.RETRY_CYCLES(16'h14)) fwl_loader_i (
        .mclk_i(mclk), .rst_i(rst), .global_reset_in_i(global_reset_in),
        .io_req_i(req), .io_wr_i(wr), .io_addr_i(addr),
        .io_wdata_i(wdata), .io_rdata_o(rdata), .io_ack_o(ack),
        .io_retry_o(retry), .core_raddr_i(craddr),
        .core_rdata_o(crdata), .core_reset_o(creset));
    fwl_host host_i (
        .mclk_i(mclk), .io_req_o(req), .io_wr_o(wr), .io_addr_o(addr),
        .io_wdata_o(wdata), .io_rdata_i(rdata), .io_ack_i(ack),
        .io_retry_i(retry));
    task check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task report_and_stop;
        $display("Checks %0d, mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            report_and_stop;
        end
    end
    task core_chk(input int a, input int e);
        @(posedge mclk);
        craddr <= a[11:0];
        @(posedge mclk);
        #1;
        check({16'h0, crdata}, e[31:0]);
    endtask
    task load(input int a, input int n);
        host_i.xfer(1'b1, 3'h4, 32'h8, q, rt);
        host_i.xfer(1'b0, 3'h4, 32'h0, q, rt);
        check(q, 32'h0);
        host_i.xfer(1'b1, 3'h0, a, q, rt);
        host_i.xfer(1'b0, 3'h0, 32'h0, q, rt);
        check(q, a);
        for (i = 0; i < n; i++) begin
            d = $random(seed);
            host_i.put(3'h0, d);
            mem[a + i] = d[15:0];
        end
    endtask
    initial begin
        seed = 32'hB1A1;
        fail_count = 0;
        total_checks = 0;
        rst = 1'b1;
        global_reset_in = 1'b0;
        craddr = 12'h0;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        check({31'h0, creset}, 32'h1);
        host_i.xfer(1'b0, 3'h4, 32'h0, q, rt);
        check(q, 32'h0);
        host_i.xfer(1'b0, 3'h2, 32'h0, q, rt);
        check(q, 32'h0);
        host_i.xfer(1'b0, 3'h0, 32'h0, q, rt);
        check(q, 32'hFFFFFFFF);
        load(256, 0);
        // Clear walk stalls the buffer: 16 taken, the next refused
        for (i = 0; i < 17; i++) begin
            d = $random(seed);
            host_i.xfer(1'b1, 3'h0, d, q, rt);
            check({31'h0, rt}, (i == 16) ? 32'h1 : 32'h0);
            mem[256 + i] = (i == 16) ? 0 : d[15:0];
        end
        host_i.put(3'h0, 32'h5A5A);
        host_i.xfer(1'b0, 3'h4, 32'h0, q, rt);
        check(q, 32'h1);
        host_i.xfer(1'b0, 3'h4, 32'h0, q, rt);
        check(q, 32'h0);
        repeat (4300) @(posedge mclk);
        load(300, 8);
        host_i.close_load(q);
        check(q, 32'h4);
        i = 0;
        while (creset !== 1'b0 && i < 100) begin
            @(posedge mclk);
            i++;
        end
        check({31'h0, creset}, 32'h0);
        foreach (mem[k]) core_chk(k, mem[k]);
        load(4096, 0);
        host_i.xfer(1'b0, 3'h4, 32'h0, q, rt);
        check(q, 32'h1);
        // Pointer is out of range: a data word is acked but lost
        host_i.put(3'h0, 32'h1234);
        host_i.xfer(1'b0, 3'h4, 32'h0, q, rt);
        check(q, 32'h1);
        check({31'h0, creset}, 32'h1);
        @(posedge mclk);
        global_reset_in <= 1'b1;
        @(posedge mclk);
        global_reset_in <= 1'b0;
        repeat (4300) @(posedge mclk);
        core_chk(300, 0);
        host_i.xfer(1'b0, 3'h0, 32'h0, q, rt);
        check(q, 32'hFFFFFFFF);
        report_and_stop;
    end
endmodule
`default_nettype wire
